// [hdl/dct_pkg.sv]
// constants and types shared by the dma channel transfer control block
// assumes one system clock and a synchronous active-low reset everywhere
package dct_pkg;

	// register map on the avalon slave (byte addresses)
	localparam logic [7:0] OFF_FLAGS = 8'h00;
	localparam logic [7:0] OFF_FLAG_CLR = 8'h04;
	localparam logic [7:0] OFF_CH_BASE = 8'h40;
	localparam int CH_STRIDE_LG = 4;
	localparam logic [3:0] OFF_CTRL = 4'h0;
	localparam logic [3:0] OFF_COUNT = 4'h4;
	localparam logic [3:0] OFF_PBASE = 4'h8;
	localparam logic [3:0] OFF_MBASE = 4'hC;

	// channel_control fields
	localparam int CTRL_W = 15;
	localparam int BIT_ENABLE = 0;
	localparam int BIT_DONE_IRQ_ON = 1;
	localparam int BIT_HALF_XFER_IRQ_ON = 2;
	localparam int BIT_XFER_ERROR_IRQ_ON = 3;
	localparam int BIT_DIR_MEM_SRC = 4;
	localparam int BIT_WRAPAROUND_MODE = 5;
	localparam int BIT_PERIPH_ADDR_AUTOINC = 6;
	localparam int BIT_MEMORY_ADDR_AUTOINC = 7;
	localparam int POS_PERIPH_ITEM_WIDTH = 8;
	localparam int POS_MEMORY_ITEM_WIDTH = 10;
	localparam int POS_PRIORITY_LEVEL = 12;
	localparam int BIT_MEMORY_TO_MEMORY_SELECT = 14;

	// per-channel flag nibble in the flag register
	localparam int FLAG_W = 3;
	localparam int FLAG_STRIDE = 4;
	localparam int FLAG_HALF = 0;
	localparam int FLAG_DONE = 1;
	localparam int FLAG_ERR = 2;

	// reset values
	localparam logic [CTRL_W-1:0] CTRL_RESET = 15'h0000;
	localparam logic [15:0] COUNT_RESET = 16'h0000;
	localparam logic [31:0] ADDR_RESET = 32'h00000000;
	localparam logic [FLAG_W-1:0] FLAG_RESET = 3'h0;

	// item width codes
	localparam logic [1:0] SIZE_BYTE = 2'h0;
	localparam logic [1:0] SIZE_HALF = 2'h1;
	localparam logic [1:0] SIZE_WORD = 2'h2;

	typedef enum logic [1:0] {ENG_IDLE, ENG_READ, ENG_WRITE} dct_eng_state_type;

	function automatic logic [31:0] dct_step(input logic [1:0] sz);
		case (sz)
			SIZE_BYTE: dct_step = 32'h00000001;
			SIZE_HALF: dct_step = 32'h00000002;
			default: dct_step = 32'h00000004;
		endcase
	endfunction

	function automatic logic [31:0] dct_mask(input logic [1:0] sz);
		case (sz)
			SIZE_BYTE: dct_mask = 32'h000000FF;
			SIZE_HALF: dct_mask = 32'h0000FFFF;
			default: dct_mask = 32'hFFFFFFFF;
		endcase
	endfunction

endpackage

// [hdl/dct_arbiter.sv]
// fixed-priority channel arbiter: highest level wins, lower index breaks ties
// assumes pending and levels come from flops on the same clock
`timescale 1ns/100ps
module dct_arbiter #(
	parameter int NUM_CH = 8,
	parameter int CHW = 3
) (
	input wire logic [NUM_CH-1:0] pending,
	input wire logic [2*NUM_CH-1:0] levels,
	output logic grant_valid,
	output logic [CHW-1:0] grant_idx
);

	logic [2:0] score [NUM_CH];

	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++) begin : g_score
			// a pending channel always outranks an idle one
			assign score[g] = pending[g] ? {1'b1, levels[2*g +: 2]} : 3'h0;
		end
	endgenerate

	always_comb begin
		logic [2:0] best;
		best = 3'h0;
		grant_idx = '0;
		// walking down with a non-strict compare lets the lowest index win a tie
		for (int i = NUM_CH - 1; i >= 0; i--) begin
			if (score[i] != 3'h0 && score[i] >= best) begin
				best = score[i];
				grant_idx = CHW'(i);
			end
		end
		grant_valid = best[2];
	end

endmodule

// [hdl/dct_dma.sv]
// multi-channel dma transfer control with avalon-mm register slave
// assumes requesting peripherals and the system bus share clk
//
// Behaviour
// - peripheral base address register holds fixed address
// - memory base address register holds memory address
// - item count decrements after each serviced item
// - two-bit priority level per channel
// - control holds direction, modes, widths, enables
// - enabled channel services its peripheral requests
// - half transfer sets flag, optional interrupt
// - completion sets done flag, optional interrupt
// - wraparound reloads count and continues servicing
// - memory-to-memory starts on enable, no request
// - memory-to-memory stops when count reaches zero
// - each item is one read then write
// - wider destination gets zero-extended value
// - narrower destination gets low bits only
// - each side steps by its own width
// - equal widths copy item unchanged
// - highest level wins, lower channel on ties
// - no service at zero; count loads disabled
// - bus error disables channel, sets error flag
//
// Added by the designer: the address map and the Avalon-MM slave port.
`timescale 1ns/100ps
module dct_dma #(
	parameter int NUM_CH = 8
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic [31:0] m_address,
	output logic m_read,
	output logic m_write,
	output logic [1:0] m_size,
	output logic [31:0] m_writedata,
	input wire logic [31:0] m_readdata,
	input wire logic m_waitrequest,
	input wire logic m_error,
	input wire logic [NUM_CH-1:0] dreq,
	output logic [NUM_CH-1:0] dack,
	output logic [NUM_CH-1:0] irq
);

	localparam int CHW = (NUM_CH > 1) ? $clog2(NUM_CH) : 1;

	////////////////////////////////////////////////////////////////////////////
	// declarations
	logic [dct_pkg::CTRL_W-1:0] ctrl_reg [NUM_CH], ctrl_next [NUM_CH];
	logic [15:0] total_reg [NUM_CH], total_next [NUM_CH];
	logic [15:0] count_reg [NUM_CH], count_next [NUM_CH];
	logic [31:0] pbase_reg [NUM_CH], pbase_next [NUM_CH];
	logic [31:0] mbase_reg [NUM_CH], mbase_next [NUM_CH];
	logic [31:0] pcur_reg [NUM_CH], pcur_next [NUM_CH];
	logic [31:0] mcur_reg [NUM_CH], mcur_next [NUM_CH];
	logic [dct_pkg::FLAG_W-1:0] flag_reg [NUM_CH], flag_next [NUM_CH];
	logic [NUM_CH-1:0] ack_reg, ack_next;
	dct_pkg::dct_eng_state_type state_reg, state_next;
	logic [CHW-1:0] ch_reg, ch_next;
	logic [31:0] addr_reg, addr_next;
	logic [1:0] size_reg, size_next;
	logic [31:0] data_reg, data_next;
	logic bus_ack_reg, bus_ack_next;
	logic [31:0] rdata_reg, rdata_next;
	logic bus_wr, ch_hit, gnt_valid, item_done, item_err;
	logic [7:0] rel_addr;
	logic [3:0] ch_sel;
	logic [NUM_CH-1:0] pending;
	logic [2*NUM_CH-1:0] levels;
	logic [CHW-1:0] gnt_idx;

	////////////////////////////////////////////////////////////////////////////
	// avalon slave decode: one wait state, read data from a flop
	assign rel_addr = avs_address - dct_pkg::OFF_CH_BASE;
	assign ch_sel = rel_addr[7:dct_pkg::CH_STRIDE_LG];
	assign ch_hit = (avs_address >= dct_pkg::OFF_CH_BASE) && (ch_sel < 4'(NUM_CH));
	assign avs_waitrequest = (avs_read || avs_write) && !bus_ack_reg;
	assign bus_wr = avs_write && bus_ack_reg;
	assign avs_readdata = rdata_reg;

	always_comb begin
		bus_ack_next = (avs_read || avs_write) && !bus_ack_reg;
		rdata_next = rdata_reg;
		if (avs_read && !bus_ack_reg) begin
			rdata_next = 32'h00000000;
			if (avs_address == dct_pkg::OFF_FLAGS) begin
				for (int i = 0; i < NUM_CH; i++) begin
					rdata_next[i*dct_pkg::FLAG_STRIDE +: dct_pkg::FLAG_W] = flag_reg[i];
				end
			end else if (ch_hit) begin
				case (rel_addr[3:0])
					dct_pkg::OFF_CTRL: rdata_next = 32'(ctrl_reg[ch_sel[CHW-1:0]]);
					dct_pkg::OFF_COUNT: rdata_next = 32'(count_reg[ch_sel[CHW-1:0]]);
					dct_pkg::OFF_PBASE: rdata_next = pbase_reg[ch_sel[CHW-1:0]];
					dct_pkg::OFF_MBASE: rdata_next = mbase_reg[ch_sel[CHW-1:0]];
					default: rdata_next = 32'h00000000;
				endcase
			end
		end
	end

	always_ff @(posedge clk) begin
		bus_ack_reg <= rst_n && bus_ack_next;
		rdata_reg <= rst_n ? rdata_next : 32'h00000000;
	end

	////////////////////////////////////////////////////////////////////////////
	// arbitration
	always_comb begin
		for (int i = 0; i < NUM_CH; i++) begin
			// a serviced peripheral must drop its request before the next item
			pending[i] = ctrl_reg[i][dct_pkg::BIT_ENABLE] && (count_reg[i] != 16'h0000) &&
				(ctrl_reg[i][dct_pkg::BIT_MEMORY_TO_MEMORY_SELECT] ||
				(dreq[i] && !ack_reg[i]));
			levels[2*i +: 2] = ctrl_reg[i][dct_pkg::POS_PRIORITY_LEVEL +: 2];
		end
	end

	dct_arbiter #(.NUM_CH(NUM_CH), .CHW(CHW)) u_arb (
		.pending(pending),
		.levels(levels),
		.grant_valid(gnt_valid),
		.grant_idx(gnt_idx)
	);

	////////////////////////////////////////////////////////////////////////////
	// transfer engine: one read then one write per item
	assign m_read = (state_reg == dct_pkg::ENG_READ);
	assign m_write = (state_reg == dct_pkg::ENG_WRITE);
	assign m_address = addr_reg;
	assign m_size = size_reg;
	assign m_writedata = data_reg;
	assign item_done = m_write && !m_waitrequest && !m_error;
	assign item_err = (m_read || m_write) && !m_waitrequest && m_error;

	always_comb begin
		logic mem_src;
		logic [1:0] psz;
		logic [1:0] msz;
		mem_src = ctrl_reg[ch_reg][dct_pkg::BIT_DIR_MEM_SRC];
		psz = ctrl_reg[ch_reg][dct_pkg::POS_PERIPH_ITEM_WIDTH +: 2];
		msz = ctrl_reg[ch_reg][dct_pkg::POS_MEMORY_ITEM_WIDTH +: 2];
		state_next = state_reg;
		ch_next = ch_reg;
		addr_next = addr_reg;
		size_next = size_reg;
		data_next = data_reg;
		case (state_reg)
			dct_pkg::ENG_IDLE: begin
				if (gnt_valid) begin
					ch_next = gnt_idx;
					state_next = dct_pkg::ENG_READ;
					if (ctrl_reg[gnt_idx][dct_pkg::BIT_DIR_MEM_SRC]) begin
						addr_next = mcur_reg[gnt_idx];
						size_next = ctrl_reg[gnt_idx][dct_pkg::POS_MEMORY_ITEM_WIDTH +: 2];
					end else begin
						addr_next = pcur_reg[gnt_idx];
						size_next = ctrl_reg[gnt_idx][dct_pkg::POS_PERIPH_ITEM_WIDTH +: 2];
					end
				end
			end
			dct_pkg::ENG_READ: begin
				if (!m_waitrequest) begin
					if (m_error) begin
						state_next = dct_pkg::ENG_IDLE;
					end else begin
						state_next = dct_pkg::ENG_WRITE;
						// masking by both widths zero-extends or truncates as needed
						data_next = m_readdata & dct_pkg::dct_mask(mem_src ? msz : psz) &
							dct_pkg::dct_mask(mem_src ? psz : msz);
						addr_next = mem_src ? pcur_reg[ch_reg] : mcur_reg[ch_reg];
						size_next = mem_src ? psz : msz;
					end
				end
			end
			dct_pkg::ENG_WRITE: begin
				if (!m_waitrequest) begin
					state_next = dct_pkg::ENG_IDLE;
				end
			end
			default: state_next = dct_pkg::ENG_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_reg <= dct_pkg::ENG_IDLE;
			ch_reg <= '0;
			addr_reg <= dct_pkg::ADDR_RESET;
			size_reg <= dct_pkg::SIZE_BYTE;
			data_reg <= 32'h00000000;
		end else begin
			state_reg <= state_next;
			ch_reg <= ch_next;
			addr_reg <= addr_next;
			size_reg <= size_next;
			data_reg <= data_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// channel state: programming, count-down, reload, flags
	always_comb begin
		logic [dct_pkg::FLAG_W-1:0] set_v;
		logic [dct_pkg::FLAG_W-1:0] clr_v;
		logic [15:0] dec_v;
		logic [dct_pkg::CTRL_W-1:0] c;
		set_v = '0;
		clr_v = '0;
		dec_v = 16'h0000;
		c = '0;
		for (int i = 0; i < NUM_CH; i++) begin
			c = ctrl_reg[i];
			ctrl_next[i] = ctrl_reg[i];
			total_next[i] = total_reg[i];
			count_next[i] = count_reg[i];
			pbase_next[i] = pbase_reg[i];
			mbase_next[i] = mbase_reg[i];
			pcur_next[i] = pcur_reg[i];
			mcur_next[i] = mcur_reg[i];
			ack_next[i] = ack_reg[i] && dreq[i];
			set_v = '0;
			clr_v = '0;
			if (bus_wr && avs_address == dct_pkg::OFF_FLAG_CLR) begin
				clr_v = avs_writedata[i*dct_pkg::FLAG_STRIDE +: dct_pkg::FLAG_W];
			end
			if (bus_wr && ch_hit && ch_sel == 4'(i)) begin
				case (rel_addr[3:0])
					dct_pkg::OFF_CTRL: begin
						ctrl_next[i] = avs_writedata[dct_pkg::CTRL_W-1:0];
						if (avs_writedata[dct_pkg::BIT_ENABLE] && !c[dct_pkg::BIT_ENABLE]) begin
							pcur_next[i] = pbase_reg[i];
							mcur_next[i] = mbase_reg[i];
						end
					end
					dct_pkg::OFF_COUNT: if (!c[dct_pkg::BIT_ENABLE]) begin
						total_next[i] = avs_writedata[15:0];
						count_next[i] = avs_writedata[15:0];
					end
					dct_pkg::OFF_PBASE: if (!c[dct_pkg::BIT_ENABLE]) begin
						pbase_next[i] = avs_writedata;
						pcur_next[i] = avs_writedata;
					end
					dct_pkg::OFF_MBASE: if (!c[dct_pkg::BIT_ENABLE]) begin
						mbase_next[i] = avs_writedata;
						mcur_next[i] = avs_writedata;
					end
					default: ;
				endcase
			end
			if (ch_reg == CHW'(i) && item_err) begin
				ctrl_next[i][dct_pkg::BIT_ENABLE] = 1'b0;
				set_v[dct_pkg::FLAG_ERR] = 1'b1;
			end
			if (ch_reg == CHW'(i) && item_done) begin
				dec_v = count_reg[i] - 16'h0001;
				count_next[i] = dec_v;
				if (c[dct_pkg::BIT_PERIPH_ADDR_AUTOINC]) begin
					pcur_next[i] = pcur_reg[i] +
						dct_pkg::dct_step(c[dct_pkg::POS_PERIPH_ITEM_WIDTH +: 2]);
				end
				if (c[dct_pkg::BIT_MEMORY_ADDR_AUTOINC]) begin
					mcur_next[i] = mcur_reg[i] +
						dct_pkg::dct_step(c[dct_pkg::POS_MEMORY_ITEM_WIDTH +: 2]);
				end
				if (dec_v == (total_reg[i] >> 1)) begin
					set_v[dct_pkg::FLAG_HALF] = 1'b1;
				end
				if (dec_v == 16'h0000) begin
					set_v[dct_pkg::FLAG_DONE] = 1'b1;
					// memory-to-memory never wraps, even if software sets both
					if (c[dct_pkg::BIT_WRAPAROUND_MODE] && !c[dct_pkg::BIT_MEMORY_TO_MEMORY_SELECT]) begin
						count_next[i] = total_reg[i];
						pcur_next[i] = pbase_reg[i];
						mcur_next[i] = mbase_reg[i];
					end
				end
				if (!c[dct_pkg::BIT_MEMORY_TO_MEMORY_SELECT]) begin
					ack_next[i] = 1'b1;
				end
			end
			// a flag raised in the cycle software clears it stays set
			flag_next[i] = (flag_reg[i] & ~clr_v) | set_v;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			for (int i = 0; i < NUM_CH; i++) begin
				ctrl_reg[i] <= dct_pkg::CTRL_RESET;
				total_reg[i] <= dct_pkg::COUNT_RESET;
				count_reg[i] <= dct_pkg::COUNT_RESET;
				pbase_reg[i] <= dct_pkg::ADDR_RESET;
				mbase_reg[i] <= dct_pkg::ADDR_RESET;
				pcur_reg[i] <= dct_pkg::ADDR_RESET;
				mcur_reg[i] <= dct_pkg::ADDR_RESET;
				flag_reg[i] <= dct_pkg::FLAG_RESET;
			end
			ack_reg <= '0;
		end else begin
			for (int i = 0; i < NUM_CH; i++) begin
				ctrl_reg[i] <= ctrl_next[i];
				total_reg[i] <= total_next[i];
				count_reg[i] <= count_next[i];
				pbase_reg[i] <= pbase_next[i];
				mbase_reg[i] <= mbase_next[i];
				pcur_reg[i] <= pcur_next[i];
				mcur_reg[i] <= mcur_next[i];
				flag_reg[i] <= flag_next[i];
			end
			ack_reg <= ack_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// per-channel outputs
	assign dack = ack_reg;

	always_comb begin
		for (int i = 0; i < NUM_CH; i++) begin
			irq[i] = (flag_reg[i][dct_pkg::FLAG_HALF] &&
				ctrl_reg[i][dct_pkg::BIT_HALF_XFER_IRQ_ON]) ||
				(flag_reg[i][dct_pkg::FLAG_DONE] && ctrl_reg[i][dct_pkg::BIT_DONE_IRQ_ON]) ||
				(flag_reg[i][dct_pkg::FLAG_ERR] && ctrl_reg[i][dct_pkg::BIT_XFER_ERROR_IRQ_ON]);
		end
	end

endmodule

// [dv/dct_bus_model.sv]
// system-bus memory model standing on the far side of the dma engine
// assumes the master holds each request until waitrequest is seen low
`timescale 1ns/100ps
module dct_bus_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [31:0] m_address,
	input wire logic m_read,
	input wire logic m_write,
	input wire logic slow,
	input wire logic err_on,
	input wire logic [31:0] err_addr,
	output logic [31:0] m_readdata,
	output logic m_waitrequest,
	output logic m_error
);
	logic [1:0] cnt_reg;
	logic [1:0] cnt_next;
	logic [31:0] last_reg;
	logic req;
	assign req = m_read | m_write;
	assign m_waitrequest = req & (cnt_reg != (slow ? 2'h2 : 2'h0));
	assign m_error = req & !m_waitrequest & err_on & (m_address == err_addr);
	// idle data shows the inverse of the last word so a stale read never matches
	assign m_readdata = (m_read & !m_waitrequest) ? ({4{m_address[7:0]}} ^ 32'hB3B2B1B0)
		: ~last_reg;
	always_comb begin
		cnt_next = m_waitrequest ? cnt_reg + 2'h1 : 2'h0;
	end
	always_ff @(posedge clk) begin
		cnt_reg <= rst_n ? cnt_next : 2'h0;
		if (!rst_n) begin
			last_reg <= 32'h0;
		end else if (m_read & !m_waitrequest) begin
			last_reg <= m_readdata;
		end
	end
endmodule

// [dv/dct_dma_assertions.sv]
// protocol checker for the dma block, attached to every dct_dma by bind
// assumes one clock and a synchronous active-low reset
`timescale 1ns/100ps
module dct_dma_assertions #(
	parameter int NUM_CH = 8
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic [31:0] m_address,
	input wire logic m_read,
	input wire logic m_write,
	input wire logic [1:0] m_size,
	input wire logic [31:0] m_writedata,
	input wire logic [31:0] m_readdata,
	input wire logic m_waitrequest,
	input wire logic m_error,
	input wire logic [NUM_CH-1:0] dreq,
	input wire logic [NUM_CH-1:0] dack,
	input wire logic [NUM_CH-1:0] irq
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_wait_first: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
		else $error("register access not stalled first");
	a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("register access took more than one wait");
	a_read_write: assert property (m_read && !m_waitrequest && !m_error |=> m_write && !m_read)
		else $error("item read not followed by its write");
	a_err_skip: assert property (m_read && !m_waitrequest && m_error |=> !m_write)
		else $error("write issued after failed read");
	a_read_hold: assert property (m_read && m_waitrequest |=> m_read && $stable(m_address))
		else $error("bus read dropped or moved while stalled");
	a_write_hold: assert property (m_write && m_waitrequest |=> m_write && $stable(m_writedata))
		else $error("bus write dropped or changed while stalled");
	a_item_gap: assert property (m_write && !m_waitrequest |=> !m_read && !m_write)
		else $error("no idle cycle between items");
	a_byte_zero: assert property (m_write && m_size == 2'h0 |-> m_writedata[31:8] == 24'h0)
		else $error("byte write upper bits not zero");
	a_half_zero: assert property (m_write && m_size == 2'h1 |-> m_writedata[31:16] == 16'h0)
		else $error("half write upper bits not zero");
	a_dack_cause: assert property ($rose(dack[0]) |-> $past(m_write && !m_waitrequest))
		else $error("acknowledge without a finished write");
	a_dack_hold: assert property (dack[0] && dreq[0] |=> dack[0])
		else $error("acknowledge dropped while request high");
	a_dack_drop: assert property (dack[0] && !dreq[0] |=> !dack[0])
		else $error("acknowledge held after request low");
	c_write: cover property (m_write && !m_waitrequest);
	c_error: cover property (m_read && m_error);
	c_ack1: cover property ($rose(dack[NUM_CH-1]));
endmodule
bind dct_dma dct_dma_assertions #(.NUM_CH(NUM_CH)) u_chk (.clk(clk), .rst_n(rst_n),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .m_address(m_address), .m_read(m_read),
	.m_write(m_write), .m_size(m_size), .m_writedata(m_writedata),
	.m_readdata(m_readdata), .m_waitrequest(m_waitrequest), .m_error(m_error),
	.dreq(dreq), .dack(dack), .irq(irq));

// [dv/tb_dct_dma.sv]
// self-checking bench for the dma channel transfer control block
// assumes dct_bus_model answers the system bus; the bench plays the peripherals
`timescale 1ns/100ps
module tb_dct_dma;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] avs_address = 8'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata, m_address, m_writedata, m_readdata, rd, pb, mb;
	logic avs_waitrequest, m_read, m_write, m_waitrequest, m_error;
	logic [1:0] m_size, ps, ms;
	logic [1:0] dreq = 2'h0;
	logic [1:0] dack, irq, l0, l1;
	logic slow = 1'b0;
	logic err_on = 1'b0;
	logic [31:0] err_addr = 32'h0;
	logic [65:0] exp_q[$];
	int fails = 0;
	int n_checks = 0;
	int cyc = 0;
	always #12.5 clk = ~clk;
	dct_dma #(.NUM_CH(2)) dut (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.m_address(m_address), .m_read(m_read), .m_write(m_write), .m_size(m_size),
		.m_writedata(m_writedata), .m_readdata(m_readdata), .m_waitrequest(m_waitrequest),
		.m_error(m_error), .dreq(dreq), .dack(dack), .irq(irq));
	dct_bus_model u_bus (.clk(clk), .rst_n(rst_n), .m_address(m_address), .m_read(m_read),
		.m_write(m_write), .slow(slow), .err_on(err_on), .err_addr(err_addr),
		.m_readdata(m_readdata), .m_waitrequest(m_waitrequest), .m_error(m_error));
	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [65:0] seen, input logic [65:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task final_report();
		if (fails == 0 && n_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	function automatic logic [7:0] ra(input int ch, input logic [3:0] off);
		return dct_pkg::OFF_CH_BASE + 8'(ch << dct_pkg::CH_STRIDE_LG) + 8'(off);
	endfunction
	function automatic logic [31:0] ctl(input logic m2m, input logic [1:0] pl,
		input logic [1:0] msz, input logic [1:0] psz, input logic [7:0] lo);
		return {17'h0, m2m, pl, msz, psz, lo};
	endfunction
	task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= !wr;
		avs_write <= wr;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	// the channel is switched off first because bases and count are locked while on
	task setup(input int ch, input logic [31:0] p, input logic [31:0] m, input logic [31:0] n,
		input logic [31:0] c);
		bus(1'b1, ra(ch, dct_pkg::OFF_CTRL), 32'h0);
		bus(1'b1, ra(ch, dct_pkg::OFF_PBASE), p);
		bus(1'b1, ra(ch, dct_pkg::OFF_MBASE), m);
		bus(1'b1, ra(ch, dct_pkg::OFF_COUNT), n);
		bus(1'b1, ra(ch, dct_pkg::OFF_CTRL), c);
	endtask
	task automatic exp_wr(input logic [31:0] a, input logic [1:0] dz, input logic [31:0] s,
		input logic [1:0] sz);
		logic [31:0] d;
		d = ({4{s[7:0]}} ^ 32'hB3B2B1B0) & 32'((64'h1 << (8 << ((dz < sz) ? dz : sz))) - 64'h1);
		exp_q.push_back({a, dz, d});
	endtask
	task serve(input int ch);
		dreq[ch] <= 1'b1;
		do @(posedge clk); while (dack[ch] !== 1'b1);
		dreq[ch] <= 1'b0;
		do @(posedge clk); while (dack[ch] !== 1'b0);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	always @(posedge clk) begin
		if (rst_n && m_write && !m_waitrequest) begin
			if (exp_q.size() == 0) check("stray write", 66'h1, 66'h0);
			else check("bus write", {m_address, m_size, m_writedata}, exp_q.pop_front());
		end
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 30000) begin
			fails++;
			final_report();
		end
	end
	initial begin
		void'($urandom(80));
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		bus(1'b0, ra(0, dct_pkg::OFF_CTRL), 32'h0);
		check("ctrl reset", rd, 32'h0);
		bus(1'b1, ra(0, dct_pkg::OFF_PBASE), 32'h1230);
		bus(1'b0, ra(0, dct_pkg::OFF_PBASE), 32'h0);
		check("pbase", rd, 32'h1230);
		bus(1'b0, 8'h30, 32'h0);
		check("unmapped", rd, 32'h0);
		// every pair of item widths, random bases and bus stalls
		for (int c = 0; c < 9; c++) begin
			ps = 2'(c / 3);
			ms = 2'(c % 3);
			pb = $urandom & 32'hFFF0;
			mb = $urandom & 32'hFFF0;
			slow <= 1'($urandom);
			for (int k = 0; k < 2; k++) exp_wr(mb + (k << ms), ms, pb + (k << ps), ps);
			setup(0, pb, mb, 32'h2, ctl(1'b0, 2'h0, ms, ps, 8'hC3));
			serve(0);
			serve(0);
			bus(1'b0, dct_pkg::OFF_FLAGS, 32'h0);
			check("flags", rd, 32'h3);
			check("irq", irq, 2'h1);
			bus(1'b0, ra(0, dct_pkg::OFF_COUNT), 32'h0);
			check("count", rd, 32'h0);
			bus(1'b1, dct_pkg::OFF_FLAG_CLR, 32'hFF);
		end
		@(posedge clk);
		check("irq clear", irq, 2'h0);
		dreq[0] <= 1'b1;
		repeat (12) @(posedge clk);
		check("ack at zero", dack, 2'h0);
		dreq[0] <= 1'b0;
		for (int k = 0; k < 3; k++) exp_wr(32'h200 + 4 * (k % 2), 2'h2, 32'h100 + 4 * (k % 2), 2'h2);
		setup(1, 32'h100, 32'h200, 32'h2, ctl(1'b0, 2'h0, 2'h2, 2'h2, 8'hE1));
		repeat (3) serve(1);
		bus(1'b0, ra(1, dct_pkg::OFF_COUNT), 32'h0);
		check("wrap count", rd, 32'h1);
		for (int k = 0; k < 3; k++) exp_wr(32'h380 + 2 * k, 2'h1, 32'h300 + 2 * k, 2'h1);
		setup(1, 32'h300, 32'h380, 32'h3, ctl(1'b1, 2'h0, 2'h1, 2'h1, 8'hC1));
		for (int k = 0; k < 40 && rd !== 32'h0; k++) bus(1'b0, ra(1, dct_pkg::OFF_COUNT), 32'h0);
		check("m2m count", rd, 32'h0);
		check("m2m ack", dack, 2'h0);
		// higher level first, then a tie that the lower channel wins
		for (int c = 0; c < 2; c++) begin
			l0 = c ? 2'h2 : 2'h0;
			l1 = c ? 2'h2 : 2'h3;
			if (l1 > l0) exp_wr(32'h50, 2'h0, 32'h40, 2'h0);
			exp_wr(32'h20, 2'h0, 32'h10, 2'h0);
			if (l1 <= l0) exp_wr(32'h50, 2'h0, 32'h40, 2'h0);
			setup(0, 32'h10, 32'h20, 32'h1, ctl(1'b0, l0, 2'h0, 2'h0, 8'hC1));
			setup(1, 32'h40, 32'h50, 32'h1, ctl(1'b0, l1, 2'h0, 2'h0, 8'hC1));
			dreq <= 2'h3;
			do @(posedge clk); while (dack !== 2'h3);
			dreq <= 2'h0;
			do @(posedge clk); while (dack !== 2'h0);
		end
		bus(1'b1, dct_pkg::OFF_FLAG_CLR, 32'hFF);
		err_on <= 1'b1;
		err_addr <= 32'h10;
		setup(0, 32'h10, 32'h20, 32'h1, ctl(1'b0, 2'h0, 2'h0, 2'h0, 8'h09));
		dreq[0] <= 1'b1;
		for (int k = 0; k < 20 && rd[2] !== 1'b1; k++) bus(1'b0, dct_pkg::OFF_FLAGS, 32'h0);
		dreq[0] <= 1'b0;
		check("err flags", rd, 32'h4);
		check("err irq", irq, 2'h1);
		bus(1'b0, ra(0, dct_pkg::OFF_CTRL), 32'h0);
		check("err ctrl", rd, 32'h8);
		check("writes left", exp_q.size(), 0);
		final_report();
	end
endmodule
